// [design/seq_pkg.sv]
// Purpose: Shared constants for the two-wire master status sequencer.
// Assumes: 32-bit APB data, one aligned word for each register.
// Notes: Status codes are held with the low three bits zero.
`default_nettype none
package seq_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DATA   = 12'h008;
  // Control register bit positions.
  localparam int BIT_FLAG  = 7;
  localparam int BIT_ACK   = 6;
  localparam int BIT_START = 5;
  localparam int BIT_STOP  = 4;
  localparam int BIT_WCOL  = 3;
  localparam int BIT_EN    = 2;
  // Values after reset.
  localparam logic [7:0] RST_DATA  = 8'hFF;
  localparam logic [7:0] RST_CODE  = 8'hF8;
  localparam logic [1:0] RST_PRESC = 2'h0;
  // Status codes.
  localparam logic [7:0] CODE_START   = 8'h08;
  localparam logic [7:0] CODE_REP     = 8'h10;
  localparam logic [7:0] CODE_AW_ACK  = 8'h18;
  localparam logic [7:0] CODE_AW_NACK = 8'h20;
  localparam logic [7:0] CODE_DW_ACK  = 8'h28;
  localparam logic [7:0] CODE_DW_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB     = 8'h38;
  localparam logic [7:0] CODE_AR_ACK  = 8'h40;
  localparam logic [7:0] CODE_AR_NACK = 8'h48;
  localparam logic [7:0] CODE_DR_ACK  = 8'h50;
  localparam logic [7:0] CODE_DR_NACK = 8'h58;
  // Bit timing: half an SCL period.
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_HALF_NS   = 5000;
  localparam logic [7:0] HALF_CYC = 8'((SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ACK_BIT  = 4'h8;
  // Sequencer states.
  typedef enum logic [11:0] {
    ST_IDLE   = 12'b0000_0000_0001,
    ST_WAIT   = 12'b0000_0000_0010,
    ST_STRT_H = 12'b0000_0000_0100,
    ST_STRT_L = 12'b0000_0000_1000,
    ST_HOLD   = 12'b0000_0001_0000,
    ST_LOW    = 12'b0000_0010_0000,
    ST_HIGH   = 12'b0000_0100_0000,
    ST_REP_A  = 12'b0000_1000_0000,
    ST_REP_B  = 12'b0001_0000_0000,
    ST_STOP_A = 12'b0010_0000_0000,
    ST_STOP_B = 12'b0100_0000_0000,
    ST_STOP_C = 12'b1000_0000_0000
  } seq_state_e;
endpackage
`default_nettype wire

// [design/i2c_master_status_sequencer.sv]
// Purpose: Master side of a byte-oriented two-wire bus with status codes, over APB.
// Assumes: SCL and SDA are open-drain pins resolved outside; pclk 25 MHz.
// Notes: Each START, byte or arbitration loss stops the sequencer until software clears the step flag; a STOP does not.
// Behaviour
// (RQ1) Start request writes enable, start, flag one.
// (RQ2) START issued only once bus is free.
// (RQ3) After START, flag set, code 0x08.
// (RQ4) Address direction bit selects transmit or receive.
// (RQ5) Load read address, then clear flag.
// (RQ6) Read address ends with 0x38, 0x40 or 0x48.
// (RQ7) Received byte readable while flag set.
// (RQ8) Software NACKs the last received byte.
// (RQ9) STOP requested by stop bit, flag one.
// (RQ10) Repeated START reports 0x10, bus kept.
// (RQ11) Acked data byte reports 0x28, next sent.
// (RQ12) Nacked data byte reports 0x30, same options.
// (RQ13) Start without stop sends repeated START.
// (RQ14) Stop alone sends STOP, clears stop bit.
// (RQ15) Start and stop: STOP, then new START.
// (RQ16) Arbitration loss reports 0x38, then release bus.
// (RQ17) After loss, start waits free bus, restarts.
// (RQ18) Status read with prescaler bits kept apart.
// (RQ19) Flag set holds the bus transfer suspended.
// (RQ20) Data write with flag low: dropped, collision.
// (RQ21) Writing zero to flag does nothing.
//
// Implementation choices: the APB register port and the register offsets.
`default_nettype none
module i2c_master_status_sequencer
  import seq_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Two-wire bus pins.
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);
  seq_state_e  state_q;
  seq_state_e  state_d;
  logic [2:0]  scl_sync_q;
  logic [2:0]  sda_sync_q;
  logic        scl_f_q;
  logic        sda_f_q;
  logic        sda_prev_q;
  logic        busy_q;
  logic        flag_q;
  logic        ack_en_q;
  logic        start_q;
  logic        stop_q;
  logic        wcol_q;
  logic        en_q;
  logic [1:0]  presc_q;
  logic [7:0]  code_q;
  logic [7:0]  data_q;
  logic [7:0]  sh_q;
  logic [3:0]  bit_q;
  logic [7:0]  cnt_q;
  logic        rx_q;
  logic        addr_q;
  logic        own_q;
  logic        lost_q;
  logic        scl_rel_q;
  logic        sda_rel_q;
  logic        wr_acc;
  logic        wr_ctrl;
  logic        wr_data;
  logic        tmr_done;
  logic        stall;
  logic        my_sda;
  logic        tx_now;
  logic        bit_end;
  logic        arb_lost;
  logic        byte_end;
  logic        start_end;
  logic        stop_end;
  logic [7:0]  byte_code;

  // APB decode; the slave always answers in the access cycle while enabled.
  assign pready  = ce;
  assign wr_acc  = psel && penable && pwrite && ce;
  assign wr_ctrl = wr_acc && (paddr == OFS_CTRL);
  assign wr_data = wr_acc && (paddr == OFS_DATA);

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (ce && psel && !penable)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      unique case (paddr)
        OFS_CTRL:   prdata[7:0] <= {flag_q, ack_en_q, start_q, stop_q, wcol_q, en_q, 2'b00};
        OFS_STATUS: prdata[7:0] <= {code_q[7:3], 1'b0, presc_q}; // RQ18
        OFS_DATA:   prdata[7:0] <= data_q; // RQ7
        default:    pslverr     <= 1'b1;
      endcase
    end
  end

  // Three-stage synchronisers; the filtered level moves once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_sync_q <= 3'b111;
      sda_sync_q <= 3'b111;
      scl_f_q    <= 1'b1;
      sda_f_q    <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      if (scl_sync_q[1] == scl_sync_q[2])
        scl_f_q <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2])
        sda_f_q <= sda_sync_q[2];
      sda_prev_q <= sda_f_q;
    end
  end

  // Bus busy tracking from START and STOP seen on the wires.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_q <= 1'b0;
    else if (ce && scl_f_q && (sda_prev_q != sda_f_q))
      busy_q <= sda_prev_q;
  end

  // Bit engine terms.
  assign tmr_done  = (cnt_q == 8'h00);
  assign stall     = !scl_f_q && ((state_q == ST_HIGH) || (state_q == ST_REP_B) || (state_q == ST_STOP_B));
  // The address byte is always sent by us, even when its direction bit asks for a read.
  assign tx_now    = !rx_q || addr_q;
  assign my_sda    = tx_now ? ((bit_q == ACK_BIT) ? 1'b1 : sh_q[7]) : ((bit_q == ACK_BIT) ? !ack_en_q : 1'b1);
  assign bit_end   = ce && (state_q == ST_HIGH) && tmr_done && scl_f_q;
  assign arb_lost  = bit_end && my_sda && !sda_f_q && ((bit_q == ACK_BIT) != tx_now); // RQ16
  assign byte_end  = bit_end && !arb_lost && (bit_q == ACK_BIT);
  assign start_end = ce && (state_q == ST_STRT_L) && tmr_done;
  assign stop_end  = ce && (state_q == ST_STOP_C) && tmr_done;

  // Status code for a finished byte, by phase and direction.
  always_comb
  begin
    if (addr_q)
      byte_code = rx_q ? (sda_f_q ? CODE_AR_NACK : CODE_AR_ACK)
                       : (sda_f_q ? CODE_AW_NACK : CODE_AW_ACK); // RQ6
    else
      byte_code = rx_q ? (sda_f_q ? CODE_DR_NACK : CODE_DR_ACK)
                       : (sda_f_q ? CODE_DW_NACK : CODE_DW_ACK); // RQ11 RQ12
  end

  // Next state of the sequencer.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:   if (en_q && start_q && !flag_q) state_d = ST_WAIT;
      ST_WAIT:   if (!busy_q) state_d = ST_STRT_H; // RQ2
      ST_STRT_H:
      begin
        if (busy_q)
          state_d = ST_WAIT; // RQ17
        else if (tmr_done && scl_f_q && sda_f_q)
          state_d = ST_STRT_L;
      end
      ST_STRT_L: if (tmr_done) state_d = ST_HOLD; // RQ3
      ST_HOLD:
      begin
        if (!flag_q)
        begin
          if (lost_q)
            state_d = start_q ? ST_WAIT : ST_IDLE; // RQ16 RQ17
          else if (stop_q)
            state_d = ST_STOP_A; // RQ14 RQ15
          else if (start_q)
            state_d = ST_REP_A; // RQ13
          else
            state_d = ST_LOW; // RQ11 RQ12
        end
      end
      ST_LOW:    if (tmr_done) state_d = ST_HIGH;
      ST_HIGH:
      begin
        if (tmr_done && scl_f_q)
          state_d = (arb_lost || (bit_q == ACK_BIT)) ? ST_HOLD : ST_LOW;
      end
      ST_REP_A:  if (tmr_done) state_d = ST_REP_B;
      ST_REP_B:  if (tmr_done && scl_f_q) state_d = ST_STRT_L;
      ST_STOP_A: if (tmr_done) state_d = ST_STOP_B;
      ST_STOP_B: if (tmr_done && scl_f_q) state_d = ST_STOP_C;
      ST_STOP_C: if (tmr_done) state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
    if (!en_q)
      state_d = ST_IDLE;
  end

  // State register and phase timer; the timer restarts on each state change.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= HALF_CYC;
    end
    else if (ce)
    begin
      state_q <= state_d;
      if ((state_d != state_q) || stall)
        cnt_q <= HALF_CYC;
      else if (!tmr_done)
        cnt_q <= cnt_q - 8'h01;
    end
  end

  // Shift register, bit count, direction and ownership.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_q   <= 8'h00;
      bit_q  <= 4'h0;
      rx_q   <= 1'b0;
      addr_q <= 1'b0;
      own_q  <= 1'b0;
      lost_q <= 1'b0;
    end
    else if (ce)
    begin
      if (start_end)
      begin
        own_q  <= 1'b1;
        addr_q <= 1'b1;
        rx_q   <= 1'b0;
      end
      if ((state_q == ST_HOLD) && (state_d == ST_LOW))
      begin
        sh_q  <= data_q;
        bit_q <= 4'h0;
        if (addr_q)
          rx_q <= data_q[0]; // RQ4
      end
      if (bit_end && !arb_lost)
      begin
        bit_q <= bit_q + 4'h1;
        if (bit_q != ACK_BIT)
          sh_q <= {sh_q[6:0], sda_f_q};
      end
      if (byte_end)
        addr_q <= 1'b0;
      if (arb_lost)
      begin
        lost_q <= 1'b1;
        own_q  <= 1'b0;
      end
      if ((state_q == ST_HOLD) && !flag_q && lost_q)
        lost_q <= 1'b0;
      if (stop_end || (state_d == ST_IDLE))
        own_q <= 1'b0;
    end
  end

  // Pin drive; released whenever the bus is not ours.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_rel_q <= 1'b1;
      sda_rel_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_rel_q <= 1'b1;
      sda_rel_q <= 1'b1;
      unique case (state_q)
        ST_STRT_L: sda_rel_q <= 1'b0;
        ST_HOLD:
        begin
          scl_rel_q <= lost_q; // RQ19
          sda_rel_q <= lost_q || sda_rel_q; // SDA holds while SCL falls.
        end
        ST_LOW:
        begin
          // SDA moves only after SCL has been low a cycle, so no false START or STOP.
          scl_rel_q <= 1'b0;
          sda_rel_q <= (cnt_q == HALF_CYC) ? sda_rel_q : my_sda;
        end
        ST_HIGH:   sda_rel_q <= my_sda;
        ST_REP_A:  scl_rel_q <= 1'b0;
        ST_STOP_A:
        begin
          scl_rel_q <= 1'b0;
          sda_rel_q <= 1'b0;
        end
        ST_STOP_B: sda_rel_q <= 1'b0;
        default:   scl_rel_q <= 1'b1;
      endcase
      if (arb_lost)
      begin
        scl_rel_q <= 1'b1;
        sda_rel_q <= 1'b1;
      end
    end
  end
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = scl_rel_q;
  assign sda_oe_n = sda_rel_q;

  // Step flag and status code; a hardware event beats a software clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_q <= 1'b0;
      code_q <= RST_CODE;
    end
    else if (ce)
    begin
      if (wr_ctrl && pwdata[BIT_FLAG])
        flag_q <= 1'b0; // RQ21
      if (start_end)
      begin
        flag_q <= 1'b1;
        code_q <= own_q ? CODE_REP : CODE_START; // RQ3 RQ10
      end
      if (arb_lost)
      begin
        flag_q <= 1'b1;
        code_q <= CODE_ARB; // RQ16
      end
      else if (byte_end)
      begin
        flag_q <= 1'b1;
        code_q <= byte_code;
      end
    end
  end

  // Control bits; the stop bit clears itself when the STOP is done.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_en_q <= 1'b0;
      start_q  <= 1'b0;
      stop_q   <= 1'b0;
      en_q     <= 1'b0;
      presc_q  <= RST_PRESC;
    end
    else if (ce)
    begin
      if (stop_end)
        stop_q <= 1'b0; // RQ14 RQ15
      if (wr_ctrl)
      begin
        ack_en_q <= pwdata[BIT_ACK];
        start_q  <= pwdata[BIT_START];
        stop_q   <= pwdata[BIT_STOP];
        en_q     <= pwdata[BIT_EN];
      end
      if (wr_acc && (paddr == OFS_STATUS))
        presc_q <= pwdata[1:0];
    end
  end

  // Data register and write collision; received bytes land here.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_q <= RST_DATA;
      wcol_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_data)
      begin
        if (flag_q)
        begin
          data_q <= pwdata[7:0];
          wcol_q <= 1'b0;
        end
        else
          wcol_q <= 1'b1; // RQ20
      end
      if (byte_end && rx_q && !addr_q)
        data_q <= sh_q; // RQ7
    end
  end

  // Checks on the sequencer.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence stop_done_s;
    stop_end && !wr_ctrl;
  endsequence
  sequence start_done_s;
    start_end && !own_q;
  endsequence
  chk_start_code: assert property (start_done_s |=> flag_q && (code_q == CODE_START)) // RQ3
    else $error("start not reported as 0x08");
  chk_rep_code: assert property (start_end && own_q |=> flag_q && (code_q == CODE_REP)) // RQ10
    else $error("repeated start not reported as 0x10");
  chk_wait_free: assert property (ce && (state_q == ST_WAIT) && busy_q |=> state_q == ST_WAIT) // RQ2
    else $error("start attempted on busy bus");
  chk_hold_bus: assert property (flag_q |-> state_q == ST_HOLD) // RQ19
    else $error("bus moved while flag set");
  chk_wcol_set: assert property (wr_data && !flag_q |=> wcol_q && $stable(data_q)) // RQ20
    else $error("data write with flag low not discarded");
  chk_flag_keep: assert property (wr_ctrl && !pwdata[BIT_FLAG] && flag_q |=> flag_q) // RQ21
    else $error("zero write cleared flag");
  chk_stop_clear: assert property (stop_done_s |=> !stop_q ##1 state_q == ST_IDLE || state_q == ST_WAIT) // RQ14
    else $error("stop bit not cleared after stop");
  chk_arb_code: assert property (arb_lost |=> flag_q && (code_q == CODE_ARB) && scl_oe_n) // RQ16
    else $error("arbitration loss not reported");
  chk_tx_ack: assert property (byte_end && !rx_q && !addr_q && !sda_f_q |=> code_q == CODE_DW_ACK) // RQ11
    else $error("acked data byte not 0x28");
  chk_rx_data: assert property (byte_end && rx_q && !addr_q |=> flag_q && (data_q == $past(sh_q))) // RQ7
    else $error("received byte not in data register");
endmodule
`default_nettype wire

// [verification/i2c_slave_model.sv]
// Purpose: Behavioural slave on the two-wire bus.
// Assumes: scl and sda are the resolved wire levels, pulled up.
// Notes: Acks its address and written bytes; returns TXB on every read byte.
`default_nettype none
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] TXB  = 8'hA5
) (
  // Bus wires.
  input  wire logic scl,
  input  wire logic sda,
  output logic      pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  int         n;
  logic       rd;
  logic       act;
  logic       adr;
  // Released and not addressed until the first START.
  initial
  begin
    pull = 1'b0;
    rd   = 1'b0;
    act  = 1'b0;
    adr  = 1'b0;
  end
  // A start begins an address byte; a stop drops the transfer.
  always @(negedge sda)
    if (scl)
    begin
      n = 0;
      adr = 1'b1;
      pull = 1'b0;
    end
  always @(posedge sda)
    if (scl)
    begin
      act = 1'b0;
      rd = 1'b0;
      pull = 1'b0;
    end
  // Bits are taken at the rising edge; a high ninth bit ends a read.
  always @(posedge scl)
  begin
    if (n < 8)
      sh = {sh[6:0], sda};
    else if (sda)
      rd = 1'b0;
    n = n + 1;
  end
  // The line changes only while SCL is low.
  always @(negedge scl)
  begin
    if (n == 8)
    begin
      if (adr)
        act = (sh[7:1] == ADDR);
      if (adr)
        rd = act & sh[0];
      pull = act & (adr | ~rd);
      adr = 1'b0;
    end
    else if (n == 9)
    begin
      n = 0;
      pull = rd & ~TXB[7];
    end
    else if (n > 0)
      pull = rd & ~TXB[7 - n];
  end
endmodule
`default_nettype wire

// [verification/i2c_master_status_sequencer_test.sv]
// Purpose: Register-level test of the two-wire master sequencer.
// Assumes: Pull-ups on both wires; a slave model and a rival pull on SDA.
// Notes: Each step writes control, waits for the step flag and checks the code.
`default_nettype none
module i2c_master_status_sequencer_test
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, pull, rival, err;
  wire logic   scl = scl_oe_n;
  wire logic   sda = sda_oe_n & ~pull & ~rival;
  int          num_errors = 0;
  int          n_compared = 0;
  // Clock of 40 ns.
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  i2c_master_status_sequencer i_i2c_master_status_sequencer (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  i2c_slave_model i_i2c_slave_model (.scl(scl), .sda(sda), .pull(pull));
  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd[7:0], exp);
  endtask
  // Polls control until bit b reads v; the watchdog ends a hang.
  task automatic poll(input int b, input logic v);
    do
    begin
      apb(1'b0, OFS_CTRL, 8'h00);
    end
    while (rd[b] !== v);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] code);
    apb(1'b1, OFS_CTRL, c);
    poll(BIT_FLAG, 1'b1);
    apb(1'b0, OFS_STATUS, 8'h00);
    chk(rd[7:0] & 8'hF8, code);
  endtask
  task automatic stop_bus;
    apb(1'b1, OFS_CTRL, 8'h94);
    poll(BIT_STOP, 1'b0);
    chk(rd[7:0], 8'h04);
    repeat (300) @(posedge pclk);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    chk({6'h00, scl_o, sda_o}, 8'h00);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog over the whole run.
  initial
  begin
    #2000000;
    num_errors++;
    complete_run;
  end
  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rival = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CTRL, 8'h00);
    rdc(OFS_STATUS, RST_CODE);
    rdc(OFS_DATA, RST_DATA);
    apb(1'b0, 12'h0FC, 8'h00);
    chk({7'h00, err}, 8'h01);
    apb(1'b1, OFS_DATA, 8'h12);
    rdc(OFS_CTRL, 8'h08);
    rdc(OFS_DATA, RST_DATA);
    apb(1'b1, OFS_STATUS, 8'h01);
    rdc(OFS_STATUS, 8'hF9);
    step(8'hA4, CODE_START);
    repeat (400) @(posedge pclk);
    chk({7'h00, scl_oe_n}, 8'h00);
    apb(1'b1, OFS_DATA, 8'h54);
    rdc(OFS_CTRL, 8'hA4);
    apb(1'b1, OFS_CTRL, 8'h24);
    rdc(OFS_STATUS, 8'h09);
    rdc(OFS_CTRL, 8'hA4);
    step(8'h84, CODE_AW_ACK);
    apb(1'b1, OFS_DATA, 8'h3C);
    step(8'h84, CODE_DW_ACK);
    step(8'hA4, CODE_REP);
    apb(1'b1, OFS_DATA, 8'h55);
    step(8'h84, CODE_AR_ACK);
    step(8'hC4, CODE_DR_ACK);
    rdc(OFS_DATA, 8'hA5);
    step(8'h84, CODE_DR_NACK);
    rdc(OFS_DATA, 8'hA5);
    stop_bus;
    step(8'hA4, CODE_START);
    apb(1'b1, OFS_DATA, 8'h60);
    step(8'h84, CODE_AW_NACK);
    apb(1'b1, OFS_DATA, 8'h11);
    step(8'h84, CODE_DW_NACK);
    step(8'hB4, CODE_START);
    rdc(OFS_CTRL, 8'hA4);
    apb(1'b1, OFS_DATA, 8'h61);
    step(8'h84, CODE_AR_NACK);
    step(8'hA4, CODE_REP);
    apb(1'b1, OFS_DATA, 8'h54);
    rival <= 1'b1;
    step(8'h84, CODE_ARB);
    apb(1'b1, OFS_CTRL, 8'h84);
    repeat (20) @(posedge pclk);
    chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    apb(1'b1, OFS_CTRL, 8'hA4);
    repeat (600) @(posedge pclk);
    rdc(OFS_CTRL, 8'h24);
    rival <= 1'b0;
    step(8'h24, CODE_START);
    stop_bus;
    complete_run;
  end
endmodule
`default_nettype wire
